//--- core/pmaf_map.svh
// register map, field positions, reset values and timing counts for the availability filter
`ifndef PMAF_MAP_SVH
`define PMAF_MAP_SVH
`define PMAF_OFF_CTRL 12'h000
`define PMAF_OFF_STAT 12'h004
`define PMAF_OFF_IRQ 12'h008
`define PMAF_OFF_MASK 12'h00C
`define PMAF_OFF_NBBE 12'h010
`define PMAF_OFF_UBBE 12'h014
`define PMAF_OFF_UES 12'h018
`define PMAF_OFF_USES 12'h01C
`define PMAF_OFF_ABBE 12'h020
`define PMAF_OFF_ZBBE 12'h024
`define PMAF_OFF_BIFL 12'h028
`define PMAF_OFF_DLY 12'h02C
`define PMAF_BIT_TRIB 0
`define PMAF_BIT_UNI 0
`define PMAF_BIT_BI 1
`define PMAF_CTRL_RST 32'h0000_0000
`define PMAF_MASK_RST 2'h0
`define PMAF_SES_RUN 10
`define PMAF_DELAY_SEC 10
`endif

//--- core/pmaf_pkg.sv
// types shared by the availability filter files
package pmaf_pkg;
  // one second's monitoring values for one direction
  typedef struct packed {
    logic [15:0] bbe;
    logic es;
    logic ses;
  } pmaf_ev_t;
  // defect and event flags for one second
  typedef struct packed {
    logic nearSes;
    logic defectSec;
    logic mfPresent;
  } pmaf_flags_t;
  // unavailable-time detector states
  typedef enum logic [1:0] {
    AVAIL = 2'b01,
    UNAVAIL = 2'b10
  } pmaf_uat_t;
endpackage

//--- core/pmaf_delay_mem.sv
// ten-stage per-second delay line, advanced on the one-second tick
`timescale 1ns/100ps
`default_nettype none
module pmaf_delay_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // per-second stream
  input wire logic tick,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_r [DEPTH]; // shift stages, last one is the read register

  initial begin
    if (DEPTH < 1 || WIDTH < 1) $error("pmaf_delay_mem: bad size");
  end

  // shift once per second; reset clears all stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) stage_r[i] <= '0;
    end else if (tick) begin
      stage_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) stage_r[i] <= stage_r[i-1];
    end
  end

  assign dout = stage_r[DEPTH-1];
endmodule // pmaf_delay_mem
`default_nettype wire

//--- core/pmaf_filter.sv
// per-second background-block-error, availability and delay filter with apb registers
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pmaf_map.svh"
// Function
// - bbe equals count unless severe or defect
// - two-mbit tributary also needs multiframe present
// - unavailable after ten consecutive severe seconds
// - available after ten seconds without severe
// - unconnected uni event inputs read as zero
// - event values delayed ten seconds
// - uni filter zeroes delayed values when unavailable
// - unavailable second output is uat state
// - report every unavailable state change
// - bi filter ors both delayed commands
// - bi filter zeroes both directions when unavailable
// - same uni filter serves any direction
// - plain ten second delay, no gating
module pmaf_filter #(
  parameter int BBE_W = 16,
  parameter int DLY_W = 8,
  parameter int RUN = `PMAF_SES_RUN,
  parameter int DEPTH = `PMAF_DELAY_SEC,
  parameter bit UNI_CONN_BBE = 1'b1,
  parameter bit UNI_CONN_ES = 1'b1,
  parameter bit UNI_CONN_SES = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-second inputs, valid with tick
  input wire logic secTick,
  input wire logic [BBE_W-1:0] block_error_count,
  input wire pmaf_pkg::pmaf_flags_t nearFlags,
  input wire pmaf_pkg::pmaf_ev_t uniIn,
  input wire pmaf_pkg::pmaf_ev_t azIn,
  input wire pmaf_pkg::pmaf_ev_t zaIn,
  input wire logic [DLY_W-1:0] plainIn,
  // per-second outputs
  output logic [BBE_W-1:0] near_bg_block_err_event,
  output pmaf_pkg::pmaf_ev_t uniOut,
  output logic uniUnavailSecond,
  output pmaf_pkg::pmaf_ev_t azOut,
  output pmaf_pkg::pmaf_ev_t zaOut,
  output logic biUnavailSecond,
  output logic [DLY_W-1:0] plainOut,
  output logic uatReport,
  output logic irq
);
  import pmaf_pkg::*;

  localparam int EVW = $bits(pmaf_ev_t);

  initial begin
    if (BBE_W != 16) $error("pmaf_filter: BBE_W must match pmaf_ev_t");
    if (RUN < 1 || RUN > 15 || DEPTH < 1) $error("pmaf_filter: bad RUN or DEPTH");
    // the plain register read pads with at least one zero bit
    if (DLY_W < 1 || DLY_W > 31) $error("pmaf_filter: bad DLY_W");
  end

  // reset release through two flops
  logic rstSync1_r, rstSync2_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  logic rstnInt;
  assign rstnInt = rstSync2_r;

  // gate an event with the unavailable state
  function automatic pmaf_ev_t gateEv(input pmaf_ev_t ev, input logic unavail);
    gateEv = unavail ? '0 : ev;
  endfunction

  // severe-run detector step: returns next state, counter
  function automatic logic [4:0] uatStep(input logic state, input logic [3:0] cnt, input logic ses);
    logic [3:0] c;
    logic s;
    c = cnt;
    s = state;
    // count seconds opposing the current state, restart on agreement
    if (ses != state) begin
      c = cnt + 4'h1;
      if (c == 4'(RUN)) begin
        s = ses;
        c = 4'h0;
      end
    end else begin
      c = 4'h0;
    end
    uatStep = {s, c};
  endfunction

  // control register: tributary mode select
  logic [31:0] ctrl_r;
  logic [1:0] irqStat_r, irqMask_r;
  logic twoMbit;
  assign twoMbit = ctrl_r[`PMAF_BIT_TRIB];

  // unconnected inputs replaced by zero
  pmaf_ev_t uniInC;
  assign uniInC.bbe = UNI_CONN_BBE ? uniIn.bbe : 16'h0000;
  assign uniInC.es = UNI_CONN_ES ? uniIn.es : 1'b0;
  assign uniInC.ses = UNI_CONN_SES ? uniIn.ses : 1'b0;

  // near-end background block error per second
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      near_bg_block_err_event <= '0;
    end else if (secTick) begin
      if (nearFlags.nearSes || nearFlags.defectSec) begin
        near_bg_block_err_event <= '0;
      end else if (twoMbit && !nearFlags.mfPresent) begin
        near_bg_block_err_event <= '0;
      end else begin
        near_bg_block_err_event <= block_error_count;
      end
    end
  end

  // unavailable-time detectors: uni, a-z, z-a (same detector for any direction)
  logic [2:0] cmd_r; // unavail_time_command per detector
  logic [3:0] cnt_r [3];
  logic [2:0] sesVec;
  assign sesVec = {zaIn.ses, azIn.ses, uniInC.ses};
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      cmd_r <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_r[i] <= 4'h0;
    end else if (secTick) begin
      for (int i = 0; i < 3; i++) begin
        {cmd_r[i], cnt_r[i]} <= uatStep(cmd_r[i], cnt_r[i], sesVec[i]);
      end
    end
  end

  // delay lines: uni events, both bi directions and bi commands, plain input
  pmaf_ev_t uniDly, azDly, zaDly;
  logic [1:0] biCmdDly;
  logic [DLY_W-1:0] plainDly;
  pmaf_delay_mem #(.WIDTH(EVW), .DEPTH(DEPTH)) uDlyUni (
    .clk(core_clk), .rstn(rstnInt), .tick(secTick), .din(uniInC), .dout(uniDly));
  pmaf_delay_mem #(.WIDTH(2 * EVW + 2), .DEPTH(DEPTH)) uDlyBi (
    .clk(core_clk), .rstn(rstnInt), .tick(secTick),
    .din({azIn, zaIn, cmd_r[2:1]}), .dout({azDly, zaDly, biCmdDly}));
  pmaf_delay_mem #(.WIDTH(DLY_W), .DEPTH(DEPTH)) uDlyPlain (
    .clk(core_clk), .rstn(rstnInt), .tick(secTick), .din(plainIn), .dout(plainDly));

  // the uni command already lines up with the ten-second-delayed events:
  // it only changes after a ten-second run, matching the delay depth
  logic uniUat, biUat;
  assign uniUat = cmd_r[0];
  assign biUat = biCmdDly[0] | biCmdDly[1];

  // gated event outputs, plain delay and state flags, updated once per second
  logic uniUat_r, biUat_r;
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      uniOut <= '0;
      azOut <= '0;
      zaOut <= '0;
      plainOut <= '0;
      uniUnavailSecond <= 1'b0;
      biUnavailSecond <= 1'b0;
      uniUat_r <= 1'b0;
      biUat_r <= 1'b0;
    end else if (secTick) begin
      uniOut <= gateEv(uniDly, uniUat);
      azOut <= gateEv(azDly, biUat);
      zaOut <= gateEv(zaDly, biUat);
      plainOut <= plainDly;
      uniUnavailSecond <= uniUat;
      biUnavailSecond <= biUat;
      uniUat_r <= uniUat;
      biUat_r <= biUat;
    end
  end

  // state-change report pulses, one cycle after the tick that moves the output
  logic uniChg, biChg;
  assign uniChg = secTick && (uniUat != uniUat_r);
  assign biChg = secTick && (biUat != biUat_r);
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      uatReport <= 1'b0;
    end else begin
      uatReport <= uniChg | biChg;
    end
  end

  // apb decode: zero-wait, unmapped address gives pslverr
  logic apbAcc, apbWr;
  logic [1:0] w1c;
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign w1c = (apbWr && paddr == `PMAF_OFF_IRQ) ? pwdata[1:0] : 2'h0;

  // control and mask registers
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      ctrl_r <= `PMAF_CTRL_RST;
      irqMask_r <= `PMAF_MASK_RST;
    end else if (apbWr) begin
      if (paddr == `PMAF_OFF_CTRL) begin
        ctrl_r <= {31'h0000_0000, pwdata[0]};
      end else if (paddr == `PMAF_OFF_MASK) begin
        irqMask_r <= pwdata[1:0];
      end
    end
  end

  // sticky change flags; a new change beats a simultaneous clear
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      irqStat_r <= 2'h0;
    end else begin
      irqStat_r[`PMAF_BIT_UNI] <= uniChg | (irqStat_r[`PMAF_BIT_UNI] & ~w1c[`PMAF_BIT_UNI]);
      irqStat_r[`PMAF_BIT_BI] <= biChg | (irqStat_r[`PMAF_BIT_BI] & ~w1c[`PMAF_BIT_BI]);
    end
  end

  // level interrupt
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // read mux and answer, registered
  logic [31:0] rdNxt;
  logic errNxt;
  always_comb begin
    rdNxt = 32'h0000_0000;
    errNxt = 1'b0;
    if (paddr == `PMAF_OFF_CTRL) begin
      rdNxt = ctrl_r;
    end else if (paddr == `PMAF_OFF_STAT) begin
      rdNxt = {28'h0, biUat, uniUat, cmd_r[2:1]};
    end else if (paddr == `PMAF_OFF_IRQ) begin
      rdNxt = {30'h0, irqStat_r};
    end else if (paddr == `PMAF_OFF_MASK) begin
      rdNxt = {30'h0, irqMask_r};
    end else if (paddr == `PMAF_OFF_NBBE) begin
      rdNxt = {16'h0, near_bg_block_err_event};
    end else if (paddr == `PMAF_OFF_UBBE) begin
      rdNxt = {16'h0, uniOut.bbe};
    end else if (paddr == `PMAF_OFF_UES) begin
      rdNxt = {31'h0, uniOut.es};
    end else if (paddr == `PMAF_OFF_USES) begin
      rdNxt = {31'h0, uniOut.ses};
    end else if (paddr == `PMAF_OFF_ABBE) begin
      rdNxt = {16'h0, azOut.bbe};
    end else if (paddr == `PMAF_OFF_ZBBE) begin
      rdNxt = {16'h0, zaOut.bbe};
    end else if (paddr == `PMAF_OFF_BIFL) begin
      rdNxt = {28'h0, zaOut.ses, zaOut.es, azOut.ses, azOut.es};
    end else if (paddr == `PMAF_OFF_DLY) begin
      rdNxt = {{(32 - DLY_W){1'b0}}, plainOut};
    end else begin
      errNxt = 1'b1;
    end
  end

  // pready pulses in the access phase one cycle after setup
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rdNxt : 32'h0000_0000;
      pslverr <= psel && !penable && errNxt;
    end
  end
endmodule // pmaf_filter
`default_nettype wire

//--- test/pmaf_checker.sv
// port assertions for the availability filter
`timescale 1ns/100ps
`default_nettype none
module pmaf_checker #(
  parameter int BBE_W = 16,
  parameter int DLY_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // per-second inputs
  input wire logic secTick,
  input wire logic [BBE_W-1:0] block_error_count,
  input wire pmaf_pkg::pmaf_flags_t nearFlags,
  input wire pmaf_pkg::pmaf_ev_t uniIn,
  // per-second outputs
  input wire logic [BBE_W-1:0] near_bg_block_err_event,
  input wire pmaf_pkg::pmaf_ev_t uniOut,
  input wire logic uniUnavailSecond,
  input wire pmaf_pkg::pmaf_ev_t azOut,
  input wire pmaf_pkg::pmaf_ev_t zaOut,
  input wire logic biUnavailSecond,
  input wire logic [DLY_W-1:0] plainOut,
  input wire logic uatReport
);
  import pmaf_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // consecutive severe and clean uni seconds, saturating, for the run checks
  logic [3:0] sesRun_r, cleanRun_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sesRun_r <= 4'h0;
      cleanRun_r <= 4'h0;
    end else if (secTick) begin
      sesRun_r <= uniIn.ses ? sesRun_r + {3'h0, sesRun_r != 4'hF} : 4'h0;
      cleanRun_r <= uniIn.ses ? 4'h0 : cleanRun_r + {3'h0, cleanRun_r != 4'hF};
    end
  end
  // a tick carrying a severe second
  sequence s_sesTick;
    secTick && uniIn.ses;
  endsequence
  // a tick carrying a clean second
  sequence s_cleanTick;
    secTick && !uniIn.ses;
  endsequence
  property p_hold;
    !secTick |=> $stable(uniOut) && $stable(plainOut) && $stable(near_bg_block_err_event);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without tick");
  property p_nearGate;
    secTick && (nearFlags.nearSes || nearFlags.defectSec) |=> near_bg_block_err_event == '0;
  endproperty
  a_nearGate: assert property (p_nearGate) else $error("near bbe not zeroed");
  property p_nearPass;
    secTick && !nearFlags.nearSes && !nearFlags.defectSec && nearFlags.mfPresent
      |=> near_bg_block_err_event == $past(block_error_count);
  endproperty
  a_nearPass: assert property (p_nearPass) else $error("near bbe not passed");
  property p_uniGate;
    uniUnavailSecond |-> uniOut == '0;
  endproperty
  a_uniGate: assert property (p_uniGate) else $error("uni events leak");
  property p_biGate;
    biUnavailSecond |-> azOut == '0 && zaOut == '0;
  endproperty
  a_biGate: assert property (p_biGate) else $error("bi events leak");
  // the output follows the command one tick later, so the run ended before that tick
  property p_riseCause;
    $rose(uniUnavailSecond) |-> $past(secTick) && $past(sesRun_r) >= 4'hA;
  endproperty
  a_riseCause: assert property (p_riseCause) else $error("unavailable without severe tick");
  property p_fallCause;
    $fell(uniUnavailSecond) |-> $past(secTick) && $past(cleanRun_r) >= 4'hA;
  endproperty
  a_fallCause: assert property (p_fallCause) else $error("available without clean tick");
  property p_report;
    $changed(uniUnavailSecond) || $changed(biUnavailSecond) |-> uatReport;
  endproperty
  a_report: assert property (p_report) else $error("state change not reported");
  c_clean: cover property (s_cleanTick ##1 $fell(uniUnavailSecond));
  c_ses: cover property (s_sesTick ##1 uniUnavailSecond);
endmodule // pmaf_checker
bind pmaf_filter pmaf_checker #(.BBE_W(BBE_W), .DLY_W(DLY_W)) pmaf_checker_inst (.core_clk, .rstn, .secTick,
  .block_error_count, .nearFlags, .uniIn, .near_bg_block_err_event, .uniOut, .uniUnavailSecond, .azOut,
  .zaOut, .biUnavailSecond, .plainOut, .uatReport);
`default_nettype wire

//--- test/pmaf_upstream.sv
// upstream source model: one second's values shown with a single tick
`timescale 1ns/100ps
`default_nettype none
module pmaf_upstream (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [80:0] vals,
  // toward the filter
  output logic secTick,
  output logic [80:0] outVals
);
  logic busy; // a second is pending
  logic [1:0] waitCnt; // idle cycles left when slow
  // values valid only with the tick; they toggle between ticks so stale reads show
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secTick <= 1'b0;
      busy <= 1'b0;
      waitCnt <= 2'h0;
      outVals <= '0;
    end else begin
      secTick <= 1'b0;
      outVals <= ~outVals;
      if (go) begin
        busy <= 1'b1;
        waitCnt <= slow ? 2'h3 : 2'h0;
      end else if (busy && waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        secTick <= 1'b1;
        outVals <= vals;
      end
    end
  end
endmodule // pmaf_upstream
`default_nettype wire

//--- test/pmaf_filter_tb_top.sv
// self-checking bench for the availability filter
`timescale 1ns/100ps
`default_nettype none
module pmaf_filter_tb_top;
  import pmaf_pkg::*;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, go, slow, secTick, uatReport, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed;
  logic [80:0] vals, upVals; // {count, flags, uni, az, za, plain}
  logic [15:0] nearOut;
  pmaf_ev_t uniOut, azOut, zaOut;
  logic uniUas, biUas, uCmd, aCmd, zCmd, biNow, runBit, uChg, bChg, uLag;
  logic [7:0] plainOut;
  logic [79:0] expQ[$]; // expected outputs, oldest first
  logic [61:0] hQ[$]; // last ten seconds of events
  logic [1:0] cQ[$]; // last ten seconds of direction commands
  int uN, aN, zN, runLeft, err_count, compares;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  pmaf_filter pmaf_filter_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .secTick(secTick),
    .block_error_count(upVals[80:65]), .nearFlags(upVals[64:62]), .uniIn(upVals[61:44]), .azIn(upVals[43:26]),
    .zaIn(upVals[25:8]), .plainIn(upVals[7:0]), .near_bg_block_err_event(nearOut), .uniOut(uniOut),
    .uniUnavailSecond(uniUas), .azOut(azOut), .zaOut(zaOut), .biUnavailSecond(biUas), .plainOut(plainOut),
    .uatReport(uatReport), .irq(irq));
  pmaf_upstream pmaf_upstream_inst (.clk(core_clk), .rstn(rstn), .go(go), .slow(slow), .vals(vals),
    .secTick(secTick), .outVals(upVals));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one direction's run detector; counts seconds that disagree with the state
  task automatic upd(inout logic cmd, inout int n, input logic ses);
    n = (ses != cmd) ? n + 1 : 0;
    if (n == 10) begin
      cmd = !cmd;
      n = 0;
    end
  endtask
  task automatic check(input logic [79:0] x, input logic [79:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chkReg(input logic [32:0] x, input logic [32:0] g);
    check({47'h0, x}, {47'h0, g});
  endtask
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // answer and data are taken at the rising edge that samples pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one random second: note the expected outputs, then hand it upstream
  task automatic sec(input logic tr);
    logic [80:0] v;
    logic [61:0] d;
    logic [1:0] cd;
    logic uo;
    seed = lfsr(seed);
    if (runLeft == 0) begin
      runBit = !runBit;
      runLeft = 8 + seed[2:0]; // runs of 8..15 straddle the ten-second edge
    end
    runLeft--;
    v = {seed[27:12], seed[30:28], seed[15:0], seed[16], runBit, seed[31:16], seed[17], runBit,
      seed[23:8], seed[18], runBit & seed[19], seed[7:0]};
    // the gate at this tick is the command as it stood before this second
    uo = uCmd;
    cd = cQ.pop_front();
    cQ.push_back({aCmd, zCmd});
    upd(uCmd, uN, v[44]);
    upd(aCmd, aN, v[26]);
    upd(zCmd, zN, v[8]);
    uChg |= (uo != uLag);
    uLag = uo;
    d = hQ.pop_front();
    hQ.push_back(v[61:0]);
    bChg |= (biNow != |cd);
    biNow = |cd;
    expQ.push_back({(v[64] | v[63] | (tr & !v[62])) ? 16'h0 : v[80:65], uo ? 18'h0 : d[61:44], uo,
      biNow ? 36'h0 : d[43:8], biNow, d[7:0]});
    vals <= v;
    slow <= seed[20];
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    do begin
      @(negedge core_clk);
    end while (secTick !== 1'b1);
    @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare each second's outputs once settled
  initial begin
    forever begin
      @(negedge core_clk);
      if (secTick === 1'b1) begin
        @(negedge core_clk);
        check(expQ.pop_front(), {nearOut, uniOut, uniUas, azOut, zaOut, biUas, plainOut});
      end
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    final_report;
  end
  initial begin
    {rstn, psel, penable, pwrite, go, slow, paddr, pwdata, vals} = '0;
    {uCmd, aCmd, zCmd, biNow, runBit, uChg, bChg, uLag} = '0;
    {uN, aN, zN, err_count, compares} = '0;
    seed = 32'h21B3;
    runLeft = 12;
    repeat (10) hQ.push_back(62'h0);
    repeat (10) cQ.push_back(2'h0);
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, 12'h000, 32'h0);
    chkReg(33'h0, {e, rdat});
    apb(1'b0, 12'hFFC, 32'h0);
    chkReg(33'h1_0000_0000, {e, rdat});
    $display("register test done");
    apb(1'b1, 12'h00C, 32'h3);
    repeat (150) sec(1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chkReg({31'h0, bChg, uChg}, {e, rdat});
    chkReg({32'h0, uChg | bChg}, {32'h0, irq});
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chkReg(33'h0, {e, rdat});
    chkReg(33'h0, {32'h0, irq});
    $display("uni and bi run test done");
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    repeat (60) sec(1'b1);
    chkReg(33'h0, {32'h0, irq});
    apb(1'b0, 12'h004, 32'h0);
    chkReg({29'h0, |cQ[0], uCmd, zCmd, aCmd}, {e, rdat});
    $display("tributary and masked test done");
    final_report;
  end
endmodule // pmaf_filter_tb_top
`default_nettype wire
